// File: usc_ctrl.sv
// Serial port control register, transmit sequencer and pin steering.
//
// What this block does
// - Second control register is readable and writable at any time.
// - Transmit-empty enable bit 7 requests interrupt while buffer-empty flag is set.
// - Bit 6 at 0 requests done interrupt; at 1 it blocks it.
// - Receive-full enable bit 5 requests interrupt while receive-full flag is set.
// - Idle-line enable bit 4 requests interrupt while idle flag is set.
// - Transmitter takes new data only with bit 3 set; it then owns the transmit pin.
// - Internal loopback releases the transmit pin even with transmitter on.
// - Single-wire mode: direction bit sets transmit pin direction.
// - Writing transmitter enable 0 then 1 queues one idle character.
// - Transmit pin held until data, idle and break frames finish.
// - Receiver enable bit 2 at 0 stops receiver and frees receive pin.
// - Writing 1 to bit 1 puts receiver in standby awaiting wakeup.
// - Wake select 0 wakes on idle line, 1 on set top data bit.
// - Hardware clears standby when the chosen wakeup condition is seen.
// - Writing break bit 1 then 0 queues one break character.
// - Break bit held at 1 with transmitter enabled keeps queuing all-zero break characters.
// - A second break may be queued depending on timing.
// - Format bit picks 8 data bits or a ninth bit before stop.
// - Loop mode: source select 0 is loopback, 1 is single wire.
`timescale 1ns/100ps
`default_nettype none

module usc_ctrl #(
  parameter int FRAME_MAX = usc_pkg::FRAME_MAX
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Status flags from the neighbouring status logic.
  input wire logic tx_buf_empty_flag_i,
  input wire logic tx_done_flag_i,
  input wire logic rx_buf_full_flag_i,
  input wire logic line_quiet_flag_i,
  // Transmit data from the data buffer.
  input wire logic tx_data_valid_i,
  input wire logic [8:0] tx_data_i,
  output logic tx_data_ready_o,
  input wire logic bit_tick_i,
  // Receiver wakeup events from the receive shifter.
  input wire logic rx_idle_seen_i,
  input wire logic rx_char_done_i,
  input wire logic rx_char_msb_i,
  // Pins.
  input wire logic tx_pin_i,
  output logic tx_pin_o,
  output logic tx_pin_oe_o,
  output logic tx_pin_use_o,
  input wire logic rx_pin_i,
  output logic rx_pin_use_o,
  // Receiver controls and line.
  output logic rx_line_o,
  output logic rx_on_o,
  output logic rx_standby_o,
  output logic nine_bit_o,
  // Transmitter activity and interrupt.
  output logic tx_active_o,
  output logic irq_o
);

  typedef struct packed {
    logic [7:0] ctl2;
    logic [7:0] ctl1;
    usc_pkg::usc_txst_t st;
    logic brk_pend;
    logic idle_pend;
    logic irq;
    logic rx_line;
    logic ack;
    logic [31:0] rdat;
  } usc_state_t;

  usc_state_t s_r;
  usc_state_t s_nxt;

  logic frm_load;
  logic [FRAME_MAX-1:0] frm_pat;
  logic [3:0] frm_len;
  logic frm_line;
  logic frm_busy;
  logic frm_done;
  logic wr_second;
  logic wr_first;
  logic take_data;
  logic tx_own;
  logic loop_int;
  logic single_wire;
  logic wake_hit;

  // =========================================================================
  // Read decode; unmapped addresses read as zero and still get an answer.
  function automatic logic [31:0] rd_mux(input logic [7:0] adr, input usc_state_t s,
                                         input logic own);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (adr)
      usc_pkg::ADR_CTL_FIRST: v[7:0] = s.ctl1;
      usc_pkg::ADR_CTL_SECOND: v[7:0] = s.ctl2;
      usc_pkg::ADR_STATUS: begin
        v[usc_pkg::S_TX_ACTIVE] = (s.st == usc_pkg::TS_SEND);
        v[usc_pkg::S_STANDBY] = s.ctl2[usc_pkg::B_STANDBY];
        v[usc_pkg::S_TX_OWN] = own;
        v[usc_pkg::S_IRQ] = s.irq;
        v[usc_pkg::S_BRK_PEND] = s.brk_pend;
        v[usc_pkg::S_IDLE_PEND] = s.idle_pend;
      end
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // =========================================================================
  // Writes land at the edge where the master sees ack, so each access
  // commits exactly once; no transmitter or receiver state blocks them.
  assign wr_second = cyc_i && stb_i && we_i && s_r.ack && sel_i[0] &&
                     (adr_i == usc_pkg::ADR_CTL_SECOND);
  assign wr_first = cyc_i && stb_i && we_i && s_r.ack && sel_i[0] &&
                    (adr_i == usc_pkg::ADR_CTL_FIRST);

  // Mode decode of the loop and source bits.
  assign loop_int = s_r.ctl1[usc_pkg::B_LOOP] && !s_r.ctl1[usc_pkg::B_SRC];
  assign single_wire = s_r.ctl1[usc_pkg::B_LOOP] && s_r.ctl1[usc_pkg::B_SRC];

  // The transmitter keeps the pin while enabled or while any frame is
  // still sending or queued, so a late break is never cut off.
  assign tx_own = s_r.ctl2[usc_pkg::B_TX_ON] || (s_r.st == usc_pkg::TS_SEND) ||
                  s_r.brk_pend || s_r.idle_pend;

  // Wakeup condition chosen by the wake select bit.
  assign wake_hit = s_r.ctl1[usc_pkg::B_WAKE] ?
                    (rx_char_done_i && rx_char_msb_i) : rx_idle_seen_i;

  // =========================================================================
  // Frame choice at a frame boundary: break first, then idle, then data.
  // Queued frames still go out after the enable drops; new data does not.
  always_comb begin
    frm_load = 1'b0;
    take_data = 1'b0;
    frm_pat = usc_pkg::IDLE_PAT;
    frm_len = s_r.ctl1[usc_pkg::B_NINE] ? usc_pkg::FRAME_LEN_9 :
              usc_pkg::FRAME_LEN_8;
    if (s_r.st == usc_pkg::TS_WAIT) begin
      if (s_r.brk_pend || (s_r.ctl2[usc_pkg::B_BREAK] && s_r.ctl2[usc_pkg::B_TX_ON])) begin
        frm_load = 1'b1;
        frm_pat = usc_pkg::BREAK_PAT;
      end else if (s_r.idle_pend) begin
        frm_load = 1'b1;
        frm_pat = usc_pkg::IDLE_PAT;
      end else if (s_r.ctl2[usc_pkg::B_TX_ON] && tx_data_valid_i) begin
        frm_load = 1'b1;
        take_data = 1'b1;
        if (s_r.ctl1[usc_pkg::B_NINE]) begin
          frm_pat = {1'b1, tx_data_i[8], tx_data_i[7:0], 1'b0};
        end else begin
          frm_pat = {2'b11, tx_data_i[7:0], 1'b0};
        end
      end
    end
  end

  // =========================================================================
  // Next state of registers, sequencer, queues and bus answer.
  always_comb begin
    s_nxt = s_r;
    // Bus answer one cycle after the request; ack drops after one cycle.
    s_nxt.ack = cyc_i && stb_i && !s_r.ack;
    if (cyc_i && stb_i && !s_r.ack) begin
      s_nxt.rdat = rd_mux(adr_i, s_r, tx_own);
    end
    // Sequencer.
    unique case (s_r.st)
      usc_pkg::TS_WAIT: begin
        if (frm_load) begin
          s_nxt.st = usc_pkg::TS_SEND;
        end
      end
      usc_pkg::TS_SEND: begin
        if (frm_done) begin
          s_nxt.st = usc_pkg::TS_WAIT;
        end
      end
    endcase
    // Queues are consumed first and set afterwards, so a write in the same
    // cycle as the consuming load still leaves a new frame queued.
    if (frm_load && (frm_pat == usc_pkg::BREAK_PAT)) begin
      s_nxt.brk_pend = 1'b0;
    end
    if (frm_load && !take_data && (frm_pat == usc_pkg::IDLE_PAT)) begin
      s_nxt.idle_pend = 1'b0;
    end
    // Hardware wakeup clears standby; a software write in the same cycle wins.
    if (s_r.ctl2[usc_pkg::B_STANDBY] && s_r.ctl2[usc_pkg::B_RX_ON] && wake_hit) begin
      s_nxt.ctl2[usc_pkg::B_STANDBY] = 1'b0;
    end
    if (wr_second) begin
      s_nxt.ctl2 = dat_i[7:0];
      if (dat_i[usc_pkg::B_TX_ON] && !s_r.ctl2[usc_pkg::B_TX_ON]) begin
        s_nxt.idle_pend = 1'b1;
      end
      if (dat_i[usc_pkg::B_BREAK] && !s_r.ctl2[usc_pkg::B_BREAK]) begin
        s_nxt.brk_pend = 1'b1;
      end
    end
    if (wr_first) begin
      s_nxt.ctl1 = dat_i[7:0];
    end
    // Merged interrupt; the done enable works inverted.
    s_nxt.irq = (s_r.ctl2[usc_pkg::B_TX_EMPTY_IE] && tx_buf_empty_flag_i) ||
                (!s_r.ctl2[usc_pkg::B_TX_DONE_IE] && tx_done_flag_i) ||
                (s_r.ctl2[usc_pkg::B_RX_FULL_IE] && rx_buf_full_flag_i) ||
                (s_r.ctl2[usc_pkg::B_QUIET_IE] && line_quiet_flag_i);
    // Receiver input: pin, own output, or the shared single wire.
    if (!s_r.ctl1[usc_pkg::B_LOOP]) begin
      s_nxt.rx_line = rx_pin_i;
    end else if (single_wire) begin
      s_nxt.rx_line = tx_pin_i;
    end else begin
      s_nxt.rx_line = frm_line;
    end
  end

  // =========================================================================
  // Register the whole state at once.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '{ctl2: usc_pkg::CTL_RESET, ctl1: usc_pkg::CTL_RESET,
               st: usc_pkg::TS_WAIT, brk_pend: 1'b0, idle_pend: 1'b0,
               irq: 1'b0, rx_line: 1'b1, ack: 1'b0, rdat: 32'h0000_0000};
    end else begin
      s_r <= s_nxt;
    end
  end

  // =========================================================================
  // Frame shifter.
  usc_tx_frame #(
    .FRAME_MAX(FRAME_MAX)
  ) u_frame (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(frm_load),
    .pattern_i(frm_pat),
    .len_i(frm_len),
    .bit_tick_i(bit_tick_i),
    .line_o(frm_line),
    .busy_o(frm_busy),
    .done_o(frm_done)
  );

  // =========================================================================
  // Outputs. Loopback hands the transmit pin back; single wire drives it
  // only while the direction bit points outward.
  assign dat_o = s_r.rdat;
  assign ack_o = s_r.ack;
  assign tx_data_ready_o = take_data;
  assign tx_pin_o = frm_line;
  assign tx_pin_use_o = tx_own && !loop_int;
  assign tx_pin_oe_o = tx_own && !loop_int &&
                       (!single_wire || s_r.ctl1[usc_pkg::B_DIR]);
  assign rx_pin_use_o = s_r.ctl2[usc_pkg::B_RX_ON] && !s_r.ctl1[usc_pkg::B_LOOP];
  assign rx_line_o = s_r.rx_line;
  assign rx_on_o = s_r.ctl2[usc_pkg::B_RX_ON];
  assign rx_standby_o = s_r.ctl2[usc_pkg::B_STANDBY];
  assign nine_bit_o = s_r.ctl1[usc_pkg::B_NINE];
  assign tx_active_o = (s_r.st == usc_pkg::TS_SEND) || frm_busy;
  assign irq_o = s_r.irq;

  // =========================================================================
  // Checks on the control behaviour.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  irq_tx_empty_a: assert property (s_r.ctl2[usc_pkg::B_TX_EMPTY_IE] &&
    tx_buf_empty_flag_i |=> irq_o) else $error("Empty request missing.");
  irq_done_pol_a: assert property (!s_r.ctl2[usc_pkg::B_TX_DONE_IE] &&
    tx_done_flag_i |=> irq_o) else $error("Done request polarity wrong.");
  irq_rx_full_a: assert property (s_r.ctl2[usc_pkg::B_RX_FULL_IE] &&
    rx_buf_full_flag_i |=> irq_o) else $error("Receive request missing.");
  irq_quiet_a: assert property (s_r.ctl2[usc_pkg::B_QUIET_IE] &&
    line_quiet_flag_i |=> irq_o) else $error("Idle request missing.");
  irq_quiet_off_a: assert property (!(s_r.ctl2[usc_pkg::B_TX_EMPTY_IE] &&
    tx_buf_empty_flag_i) && !(!s_r.ctl2[usc_pkg::B_TX_DONE_IE] && tx_done_flag_i) &&
    !(s_r.ctl2[usc_pkg::B_RX_FULL_IE] && rx_buf_full_flag_i) &&
    !(s_r.ctl2[usc_pkg::B_QUIET_IE] && line_quiet_flag_i) |=> !irq_o)
    else $error("Interrupt without enabled flag.");
  tx_gate_a: assert property (tx_data_ready_o |->
    s_r.ctl2[usc_pkg::B_TX_ON]) else $error("Data taken while off.");
  loop_release_a: assert property (loop_int |-> !tx_pin_oe_o &&
    !tx_pin_use_o) else $error("Pin held in loopback.");
  wire_dir_a: assert property (single_wire && tx_own |->
    tx_pin_oe_o == s_r.ctl1[usc_pkg::B_DIR]) else $error("Wrong wire direction.");
  idle_queue_a: assert property (wr_second && dat_i[usc_pkg::B_TX_ON] &&
    !s_r.ctl2[usc_pkg::B_TX_ON] |=> s_r.idle_pend) else $error("Idle not queued.");
  // A frame that ends in this very cycle may legally hand the pin back next cycle.
  hold_pin_a: assert property ($fell(s_r.ctl2[usc_pkg::B_TX_ON]) && !frm_done &&
    s_r.st == usc_pkg::TS_SEND |=> tx_pin_use_o || loop_int)
    else $error("Pin dropped mid frame.");
  rx_release_a: assert property (!s_r.ctl2[usc_pkg::B_RX_ON] |->
    !rx_pin_use_o) else $error("Receive pin held while off.");
  standby_wake_a: assert property (rx_standby_o && rx_on_o && wake_hit &&
    !wr_second |=> !rx_standby_o) else $error("Wakeup ignored.");
  standby_keep_a: assert property (rx_standby_o && !wake_hit &&
    !wr_second |=> rx_standby_o) else $error("Standby left early.");
  wake_sel_a: assert property (rx_standby_o && rx_on_o &&
    s_r.ctl1[usc_pkg::B_WAKE] && !(rx_char_done_i && rx_char_msb_i) && !wr_second
    |=> rx_standby_o) else $error("Wrong wakeup source.");
  break_queue_a: assert property (wr_second && dat_i[usc_pkg::B_BREAK] &&
    !s_r.ctl2[usc_pkg::B_BREAK] |=> s_r.brk_pend) else $error("Break not queued.");
  break_len_a: assert property (frm_load && frm_pat == usc_pkg::BREAK_PAT |->
    frm_len == (s_r.ctl1[usc_pkg::B_NINE] ? 4'hb : 4'ha)) else $error("Break length.");
  break_hold_a: assert property (s_r.st == usc_pkg::TS_WAIT && s_r.ctl2[usc_pkg::B_BREAK]
    && s_r.ctl2[usc_pkg::B_TX_ON] |-> frm_load && frm_pat == usc_pkg::BREAK_PAT)
    else $error("Held break not repeated.");
  second_break_a: assert property (frm_load && frm_pat == usc_pkg::BREAK_PAT &&
    wr_second && dat_i[usc_pkg::B_BREAK] && !s_r.ctl2[usc_pkg::B_BREAK] |=> s_r.brk_pend)
    else $error("Late break lost.");
  nine_frame_a: assert property (take_data && s_r.ctl1[usc_pkg::B_NINE] |->
    frm_pat[9] == tx_data_i[8] && !frm_pat[0]) else $error("Ninth bit misplaced.");
  access_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("Register access stalled.");
  wire_src_a: assert property (single_wire |=> rx_line_o == $past(tx_pin_i))
    else $error("Single wire source wrong.");
  // Once the transmitter is off and nothing is left queued, the pin goes back.
  tx_release_a: assert property (!s_r.ctl2[usc_pkg::B_TX_ON] && !s_r.brk_pend &&
    !s_r.idle_pend && s_r.st == usc_pkg::TS_WAIT |-> !tx_pin_use_o && !tx_pin_oe_o)
    else $error("Pin kept after transmitter off.");
  // An enabled transmitter outside internal loopback owns its pin.
  tx_claim_a: assert property (s_r.ctl2[usc_pkg::B_TX_ON] && !loop_int |->
    tx_pin_use_o) else $error("Transmit pin not taken.");
  // An enabled receiver outside loop mode owns its pin.
  rx_claim_a: assert property (rx_on_o && !s_r.ctl1[usc_pkg::B_LOOP] |->
    rx_pin_use_o) else $error("Receive pin not taken.");

endmodule
`default_nettype wire

// File: usc_ctrl_tb_top.sv
// Self-checking bench for the serial port control block.
`timescale 1ns/100ps
`default_nettype none

module usc_ctrl_tb_top;
  localparam logic [7:0] c1_adr = usc_pkg::ADR_CTL_FIRST;
  localparam logic [7:0] c2_adr = usc_pkg::ADR_CTL_SECOND;
  // ==========================================================================
  // Stimulus and observation signals.
  logic clk_i;
  logic rst_i = 1'h1;
  logic cyc = 1'h0, stb = 1'h0, we = 1'h0, tick = 1'h0, tx_valid = 1'h0, clr = 1'h0;
  logic idle_seen = 1'h0, char_done = 1'h0, char_msb = 1'h0, rx_pin = 1'h1;
  logic far_en = 1'h0, far_val = 1'h1;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0, flags = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, hist;
  logic [8:0] tx_data = 9'h000;
  logic [1:0] tc = 2'h0;
  logic [5:0] nbits;
  logic ack, tx_ready, line, tx_o, tx_oe, tx_use, rx_use, rx_line, rx_on, stby, nine, active, irq;
  int miscompares = 0, n_checks = 0, cycles = 0;

  usc_ctrl i_usc_ctrl (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .tx_buf_empty_flag_i(flags[0]), .tx_done_flag_i(flags[1]),
    .rx_buf_full_flag_i(flags[2]), .line_quiet_flag_i(flags[3]),
    .tx_data_valid_i(tx_valid), .tx_data_i(tx_data), .tx_data_ready_o(tx_ready),
    .bit_tick_i(tick), .rx_idle_seen_i(idle_seen), .rx_char_done_i(char_done),
    .rx_char_msb_i(char_msb), .tx_pin_i(line), .tx_pin_o(tx_o), .tx_pin_oe_o(tx_oe),
    .tx_pin_use_o(tx_use), .rx_pin_i(rx_pin), .rx_pin_use_o(rx_use), .rx_line_o(rx_line),
    .rx_on_o(rx_on), .rx_standby_o(stby), .nine_bit_o(nine), .tx_active_o(active), .irq_o(irq));

  usc_line_model i_usc_line_model (
    .clk_i(clk_i), .rst_i(rst_i), .bit_tick_i(tick), .active_i(active), .clr_i(clr),
    .pin_i(tx_o), .pin_oe_i(tx_oe), .far_en_i(far_en), .far_val_i(far_val), .line_o(line),
    .hist_o(hist), .nbits_o(nbits));

  // Clock at 100 ns; a bit time is four clocks to keep frames short.
  initial begin
    clk_i = 1'h0;
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    tc <= tc + 2'h1;
    tick <= (tc == 2'h3);
  end

  // ==========================================================================
  // Shared tasks.
  task automatic check_vec(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic check_bit(input string name, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // One classic cycle; the request holds until ack is seen, and the answer is taken then.
  task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [7:0] d,
                          output logic [31:0] q);
    int i;
    @(posedge clk_i);
    {cyc, stb, we, adr, sel, wdat} <= {1'h1, 1'h1, w, a, 4'hf, 24'h0, d};
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (ack !== 1'h1 && i < 50);
    check_bit("ack", 1'h1, ack);
    q = rdat;
    {cyc, stb, we} <= 3'h0;
    @(negedge clk_i);
  endtask
  task automatic wb_wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb_cycle(1'h1, a, d, q);
  endtask
  task automatic send(input logic [8:0] d);
    int i;
    @(posedge clk_i);
    {tx_valid, tx_data} <= {1'h1, d};
    i = 0;
    do begin
      @(negedge clk_i);
      i++;
    end while (tx_ready !== 1'h1 && i < 600);
    check_bit("ready", 1'h1, tx_ready);
    @(posedge clk_i);
    tx_valid <= 1'h0;
  endtask
  // Back-to-back frames leave one quiet cycle, so four quiet cycles mean truly idle.
  task automatic wait_idle;
    int q, i;
    q = 0;
    i = 0;
    while (q < 4 && i < 900) begin
      @(negedge clk_i);
      i++;
      q = (active === 1'h0) ? q + 1 : 0;
    end
    check_bit("idle", 1'h1, q >= 4);
  endtask
  task automatic pulse(input int k);
    @(posedge clk_i);
    {clr, idle_seen, char_done} <= 3'h4 >> k;
    @(posedge clk_i);
    {clr, idle_seen, char_done} <= 3'h0;
    repeat (2) @(negedge clk_i);
  endtask

  // ==========================================================================
  // Scenarios.
  task automatic t_reset;
    logic [31:0] q;
    wb_cycle(1'h0, c2_adr, 8'h00, q);
    check_vec("ctl2", {24'h0, usc_pkg::CTL_RESET}, q);
    wb_cycle(1'h0, 8'hfc, 8'h00, q);
    check_vec("unmapped", 32'h0, q);
    check_bit("tx_use", 1'h0, tx_use);
    check_bit("rx_use", 1'h0, rx_use);
    $display("test reset done");
  endtask
  task automatic t_irq;
    for (int i = 0; i < 4; i++) begin
      wb_wr(c2_adr, (i == 1) ? 8'h00 : 8'(8'h80 >> i));
      @(posedge clk_i);
      flags <= 4'(4'h1 << i);
      repeat (2) @(negedge clk_i);
      check_bit("irq_on", 1'h1, irq);
      wb_wr(c2_adr, (i == 1) ? 8'h40 : 8'h00);
      repeat (2) @(negedge clk_i);
      check_bit("irq_off", 1'h0, irq);
      @(posedge clk_i);
      flags <= 4'h0;
    end
    $display("test irq done");
  endtask
  task automatic t_tx8;
    pulse(0);
    wb_wr(c2_adr, 8'h08);
    send(9'h05a);
    check_bit("tx_oe", 1'h1, tx_oe);
    wb_wr(c2_adr, 8'h00);
    check_bit("use_hold", 1'h1, tx_use);
    wb_wr(c2_adr, 8'h08);
    wait_idle;
    check_vec("nbits8", 32'd30, 32'(nbits));
    check_vec("frames8", {2'h0, 10'h3ff, 1'h1, 8'h5a, 1'h0, 10'h3ff}, hist >> (32 - nbits));
    $display("test tx8 done");
  endtask
  task automatic t_nine;
    logic [31:0] q;
    wb_wr(c1_adr, 8'h10);
    check_bit("nine", 1'h1, nine);
    pulse(0);
    wb_wr(c2_adr, 8'h09);
    wb_cycle(1'h0, c2_adr, 8'h00, q);
    check_vec("ctl2_busy", 32'h9, q);
    wb_wr(c2_adr, 8'h00);
    check_bit("brk_use", 1'h1, tx_use);
    wait_idle;
    check_vec("brk9", 32'h0, {26'h0, nbits} ^ 32'd11 | hist);
    check_bit("released", 1'h0, tx_use);
    pulse(0);
    wb_wr(c2_adr, 8'h08);
    send(9'h1a5);
    wait_idle;
    check_vec("frames9", {10'h0, 2'h3, 8'ha5, 1'h0, 11'h7ff}, hist >> (32 - nbits));
    $display("test nine done");
  endtask
  task automatic t_hold;
    wb_wr(c1_adr, 8'h00);
    pulse(0);
    wb_wr(c2_adr, 8'h09);
    repeat (120) @(posedge clk_i);
    wb_wr(c2_adr, 8'h08);
    wait_idle;
    check_bit("brk_count", 1'h1, (nbits % 10 == 0) && (nbits >= 30));
    check_vec("brk_zero", 32'h0, hist);
    $display("test hold done");
  endtask
  task automatic t_pins;
    wb_wr(c2_adr, 8'h0c);
    check_bit("rx_use", 1'h1, rx_use & rx_on);
    @(posedge clk_i);
    rx_pin <= 1'h0;
    repeat (2) @(negedge clk_i);
    check_bit("rx_line", 1'h0, rx_line);
    wb_wr(c1_adr, 8'h80);
    @(negedge clk_i);
    check_bit("loop_use", 1'h0, tx_use);
    check_bit("loop_rx", 1'h1, rx_line);
    wb_wr(c1_adr, 8'ha1);
    check_bit("sw_out", 1'h1, tx_oe);
    wb_wr(c1_adr, 8'ha0);
    @(posedge clk_i);
    {far_en, far_val} <= 2'h2;
    repeat (2) @(negedge clk_i);
    check_bit("sw_in", 1'h0, tx_oe);
    check_bit("sw_rx", 1'h0, rx_line);
    @(posedge clk_i);
    {far_en, far_val, rx_pin} <= 3'h3;
    wb_wr(c2_adr, 8'h00);
    check_bit("rx_free", 1'h0, rx_use);
    $display("test pins done");
  endtask
  task automatic t_standby;
    wb_wr(c1_adr, 8'h00);
    wb_wr(c2_adr, 8'h06);
    check_bit("stby_set", 1'h1, stby);
    char_msb <= 1'h1;
    pulse(2);
    check_bit("msb_ignored", 1'h1, stby);
    pulse(1);
    check_bit("idle_wake", 1'h0, stby);
    wb_wr(c1_adr, 8'h08);
    wb_wr(c2_adr, 8'h06);
    pulse(1);
    check_bit("idle_ignored", 1'h1, stby);
    char_msb <= 1'h0;
    pulse(2);
    check_bit("msb_low", 1'h1, stby);
    char_msb <= 1'h1;
    pulse(2);
    check_bit("msb_wake", 1'h0, stby);
    $display("test standby done");
  endtask

  // Hang guard: the whole run needs well under a thousand cycles.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      report_and_stop;
    end
  end
  // Main sequence.
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'h0;
    t_reset;
    t_irq;
    t_tx8;
    t_nine;
    t_hold;
    t_pins;
    t_standby;
    report_and_stop;
  end
endmodule
`default_nettype wire

// File: usc_line_model.sv
// Far-side line partner: resolves the shared transmit line and records its bit times.
`timescale 1ns/100ps
`default_nettype none

module usc_line_model (
  // Clock, reset and bit timing.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic bit_tick_i,
  input wire logic active_i,
  input wire logic clr_i,
  // Shared transmit line.
  input wire logic pin_i,
  input wire logic pin_oe_i,
  input wire logic far_en_i,
  input wire logic far_val_i,
  output logic line_o,
  // Recorded bit times, newest at the top.
  output logic [31:0] hist_o,
  output logic [5:0] nbits_o
);
  // The line has a pull-up, so a released line reads high.
  assign line_o = pin_oe_i ? pin_i : (far_en_i ? far_val_i : 1'h1);

  // One sample as each bit time ends; only frame bits count, so idle gaps stay out.
  always_ff @(posedge clk_i) begin
    if (rst_i || clr_i) begin
      hist_o <= 32'h0;
      nbits_o <= 6'h0;
    end else if (bit_tick_i && active_i) begin
      hist_o <= {line_o, hist_o[31:1]};
      nbits_o <= nbits_o + 6'h1;
    end
  end
endmodule
`default_nettype wire

// File: usc_pkg.sv
// Shared constants and types for the serial port control block.
package usc_pkg;

  // ==========================================================================
  // Register byte addresses on the bus.
  localparam logic [7:0] ADR_CTL_FIRST = 8'h00;
  localparam logic [7:0] ADR_CTL_SECOND = 8'h04;
  localparam logic [7:0] ADR_STATUS = 8'h08;
  localparam logic [7:0] CTL_RESET = 8'h00;

  // ==========================================================================
  // Field positions of serial_control_second.
  localparam int B_TX_EMPTY_IE = 7;
  localparam int B_TX_DONE_IE = 6;
  localparam int B_RX_FULL_IE = 5;
  localparam int B_QUIET_IE = 4;
  localparam int B_TX_ON = 3;
  localparam int B_RX_ON = 2;
  localparam int B_STANDBY = 1;
  localparam int B_BREAK = 0;

  // ==========================================================================
  // Field positions of serial_control_first.
  localparam int B_LOOP = 7;
  localparam int B_SRC = 5;
  localparam int B_NINE = 4;
  localparam int B_WAKE = 3;
  localparam int B_DIR = 0;

  // ==========================================================================
  // Field positions of the status register.
  localparam int S_TX_ACTIVE = 0;
  localparam int S_STANDBY = 1;
  localparam int S_TX_OWN = 2;
  localparam int S_IRQ = 3;
  localparam int S_BRK_PEND = 4;
  localparam int S_IDLE_PEND = 5;

  // ==========================================================================
  // Frame shapes, least significant bit sent first.
  localparam int FRAME_MAX = 11;
  localparam logic [3:0] FRAME_LEN_8 = 4'ha;
  localparam logic [3:0] FRAME_LEN_9 = 4'hb;
  localparam logic [10:0] IDLE_PAT = 11'h7ff;
  localparam logic [10:0] BREAK_PAT = 11'h000;

  // Transmit sequencer states.
  typedef enum logic [1:0] {
    TS_WAIT = 2'b01,
    TS_SEND = 2'b10
  } usc_txst_t;

endpackage

// File: usc_tx_frame.sv
// Bit shifter that sends one frame of up to eleven bit times on the line.
`timescale 1ns/100ps
`default_nettype none

module usc_tx_frame #(
  parameter int FRAME_MAX = 11
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Frame request.
  input wire logic load_i,
  input wire logic [FRAME_MAX-1:0] pattern_i,
  input wire logic [3:0] len_i,
  input wire logic bit_tick_i,
  // Line and progress.
  output logic line_o,
  output logic busy_o,
  output logic done_o
);

  typedef struct packed {
    logic [FRAME_MAX-1:0] sh;
    logic [3:0] cnt;
    logic busy;
    logic line;
    logic done;
  } usc_frm_t;

  usc_frm_t s_r;
  usc_frm_t s_nxt;

  // =========================================================================
  // Next state; the line rests high between frames so it reads as idle.
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (load_i) begin
      s_nxt.sh = pattern_i;
      s_nxt.cnt = len_i;
      s_nxt.busy = 1'b1;
      s_nxt.line = pattern_i[0];
    end else if (s_r.busy && bit_tick_i) begin
      if (s_r.cnt == 4'h1) begin
        s_nxt.busy = 1'b0;
        s_nxt.line = 1'b1;
        s_nxt.done = 1'b1;
      end else begin
        s_nxt.sh = s_r.sh >> 1;
        s_nxt.line = s_r.sh[1];
        s_nxt.cnt = s_r.cnt - 4'h1;
      end
    end
  end

  // Register the whole state at once.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '{sh: '1, cnt: 4'h0, busy: 1'b0, line: 1'b1, done: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign line_o = s_r.line;
  assign busy_o = s_r.busy;
  assign done_o = s_r.done;

endmodule
`default_nettype wire
